/* File: common/usbppc_pkg.sv */
// Constants and types shared by the USB PHY power control slice
package usbppc_pkg;
   // Register byte offsets
   localparam logic [11:0] OFS_POWER_SIGNAL = 12'h03c;
   localparam logic [11:0] OFS_PHY_CONTROL = 12'h040;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h044;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h048;
   localparam logic [11:0] OFS_PHY_STATUS = 12'h04c;
   // Power signalling fields
   localparam int PS_DATA_POS = 0;
   localparam int PS_DATA_W = 8;
   localparam int PS_VALID_POS = 8;
   // PHY control fields
   localparam int PC_CONF_POS = 4;
   localparam int PC_CONF_W = 3;
   localparam int PC_AUTO_POS = 7;
   localparam int PC_FLT_POS = 8;
   localparam int PC_FLT_W = 4;
   localparam int PC_RESUME_POS = 12;
   localparam int PC_RESET_POS = 13;
   localparam int PC_PDDIS_POS = 18;
   // Interrupt status and mask fields
   localparam int IRQ_W = 2;
   localparam int IRQ_RESUME_POS = 0;
   localparam int IRQ_RESET_POS = 1;
   // Filtered line state and suspend fields in the PHY status register
   localparam int ST_LINE_POS = 0;
   localparam int ST_SUSP_POS = 2;
   // Line state encodings and the idle value after reset
   localparam logic [1:0] LS_SE0 = 2'h0;
   localparam logic [1:0] LS_J = 2'h1;
   localparam logic [1:0] LS_K = 2'h2;
   localparam logic [1:0] LS_RESET = LS_J;
   // Suspend controller states, Gray coded along run, idle, wake
   typedef enum logic [1:0] {
      SUSP_RUN = 2'h0,
      SUSP_IDLE = 2'h1,
      SUSP_WAKE = 2'h3
   } usbppc_susp_type;
endpackage : usbppc_pkg

/* File: hdl/usbppc_filter.sv */
// Line state synchroniser and change filter
`timescale 1ns/100ps
module usbppc_filter #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Raw line state from the PHY pins
   input wire logic [1:0] lineRaw,
   // Log-2 filter length
   input wire logic [3:0] log2Len,
   // Filtered line state
   output logic [1:0] lineFilt
);
   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] cand;
      logic [1:0] filt;
      logic [CNT_W-1:0] cnt;
   } usbppc_flt_type;

   usbppc_flt_type s_q;
   usbppc_flt_type s_d;
   logic [CNT_W-1:0] target;
   // Idle line level for every stage after reset
   localparam logic [1:0] LS_RESET_C = usbppc_pkg::LS_RESET;

   assign target = CNT_W'(1) << log2Len;
   assign lineFilt = s_q.filt;

   always_comb
   begin
      s_d = s_q;
      s_d.sync1 = lineRaw;
      s_d.sync2 = s_q.sync1;
      // Any new value restarts the stability count
      if (s_q.sync2 != s_q.cand)
      begin
         s_d.cand = s_q.sync2;
         s_d.cnt = CNT_W'(1);
      end
      else if (s_q.cand != s_q.filt)
      begin
         if (s_q.cnt >= target)
            s_d.filt = s_q.cand;
         else
            s_d.cnt = s_q.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         s_q <= '{sync1: LS_RESET_C, sync2: LS_RESET_C, cand: LS_RESET_C,
                  filt: LS_RESET_C, cnt: '0};
      else
         s_q <= s_d;
   end

   chk_filter_delay: assert property (@(posedge clk)
      disable iff (reset)
      (s_q.cand != s_q.filt && s_q.sync2 == s_q.cand && s_q.cnt >= target)
      |=> lineFilt == $past(s_q.cand))
      else $error("filtered line state did not follow after delay");

   chk_filter_hold: assert property (@(posedge clk)
      disable iff (reset)
      (s_q.cnt < target && $stable(log2Len)) |=> $stable(lineFilt))
      else $error("filtered line state changed too early");
endmodule : usbppc_filter

/* File: hdl/usbppc_top.sv */
// APB register slice for USB PHY power control and suspend resume
`timescale 1ns/100ps
module usbppc_top #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // PHY side
   input wire logic [1:0] lineState,
   output logic [2:0] transceiverConfigPins,
   output logic widePortFirstPdEn,
   output logic widePortSecondPdEn,
   output logic phySuspend_n,
   // Interface unit side
   input wire logic suspendReq,
   output logic resumeDone,
   output logic [7:0] powerSignalData,
   output logic powerSignalValid,
   output logic [1:0] lineStateFilt,
   output logic irq
);
   typedef struct packed {
      logic [7:0] psData;
      logic psValid;
      logic pdDis;
      logic rstCause;
      logic resCause;
      logic [3:0] fltLog;
      logic autoRes;
      logic [2:0] conf;
      logic [1:0] irqSt;
      logic [1:0] irqMask;
      usbppc_pkg::usbppc_susp_type st;
      logic wideEn1;
      logic wideEn2;
      logic suspN;
      logic resume;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } usbppc_state_type;

   usbppc_state_type s_q;
   usbppc_state_type s_d;
   logic [1:0] filt;
   logic wrEn;
   logic accDone;
   logic wakeSe0;
   logic wakeK;

   // Matches a byte address against a register offset
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [11:0] ofs);
      hit = (a == ADDR_W'(ofs));
   endfunction : hit

   // Reads one bit of write data at a field position
   function automatic logic wbit(input logic [31:0] d, input int pos);
      wbit = d[pos];
   endfunction : wbit

   usbppc_filter #(
      .CNT_W(16)
   ) u_filter (
      .clk(clk),
      .reset(reset),
      .lineRaw(lineState),
      .log2Len(s_q.fltLog),
      .lineFilt(filt)
   );

   // Access phase ends on the second cycle, so pready is a flop
   assign accDone = psel & penable & s_q.pready;
   assign wrEn = accDone & pwrite;
   // Only the controller's own wake from idle counts as an auto-resume
   assign wakeSe0 = (s_q.st == usbppc_pkg::SUSP_IDLE) & s_q.autoRes
                    & (filt == usbppc_pkg::LS_SE0);
   assign wakeK = (s_q.st == usbppc_pkg::SUSP_IDLE) & s_q.autoRes
                  & (filt == usbppc_pkg::LS_K);

   always_comb
   begin
      s_d = s_q;
      s_d.resume = 1'b0;
      // Register writes
      if (wrEn && hit(paddr, usbppc_pkg::OFS_POWER_SIGNAL))
      begin
         s_d.psData = pwdata[usbppc_pkg::PS_DATA_POS +:
                             usbppc_pkg::PS_DATA_W];
         s_d.psValid = wbit(pwdata, usbppc_pkg::PS_VALID_POS);
      end
      if (wrEn && hit(paddr, usbppc_pkg::OFS_PHY_CONTROL))
      begin
         s_d.pdDis = wbit(pwdata, usbppc_pkg::PC_PDDIS_POS);
         s_d.rstCause = wbit(pwdata, usbppc_pkg::PC_RESET_POS);
         s_d.resCause = wbit(pwdata, usbppc_pkg::PC_RESUME_POS);
         s_d.fltLog = pwdata[usbppc_pkg::PC_FLT_POS +:
                             usbppc_pkg::PC_FLT_W];
         s_d.autoRes = wbit(pwdata, usbppc_pkg::PC_AUTO_POS);
         s_d.conf = pwdata[usbppc_pkg::PC_CONF_POS +:
                           usbppc_pkg::PC_CONF_W];
      end
      if (wrEn && hit(paddr, usbppc_pkg::OFS_IRQ_STATUS))
         s_d.irqSt = s_q.irqSt & ~pwdata[usbppc_pkg::IRQ_W-1:0];
      if (wrEn && hit(paddr, usbppc_pkg::OFS_IRQ_MASK))
         s_d.irqMask = pwdata[usbppc_pkg::IRQ_W-1:0];

      // Suspend controller
      case (s_q.st)
         usbppc_pkg::SUSP_RUN:
         begin
            if (suspendReq)
               s_d.st = usbppc_pkg::SUSP_IDLE;
         end
         usbppc_pkg::SUSP_IDLE:
         begin
            // With auto-resume off, software watches the line and
            // the interface unit drops the request itself
            if (wakeSe0 || wakeK)
            begin
               s_d.st = usbppc_pkg::SUSP_WAKE;
               s_d.resume = 1'b1;
            end
            else if (!suspendReq)
               s_d.st = usbppc_pkg::SUSP_RUN;
         end
         usbppc_pkg::SUSP_WAKE:
         begin
            if (!suspendReq)
               s_d.st = usbppc_pkg::SUSP_RUN;
         end
         default:
            s_d.st = usbppc_pkg::SUSP_RUN;
      endcase

      // Hardware sets win over a software clear in the same cycle
      if (wakeSe0)
      begin
         s_d.rstCause = 1'b1;
         s_d.irqSt[usbppc_pkg::IRQ_RESET_POS] = 1'b1;
      end
      if (wakeK)
      begin
         s_d.resCause = 1'b1;
         s_d.irqSt[usbppc_pkg::IRQ_RESUME_POS] = 1'b1;
      end

      // Outputs follow the next register values so they stay flops
      s_d.wideEn1 = ~s_d.pdDis;
      s_d.wideEn2 = ~s_d.pdDis;
      s_d.suspN = (s_d.st == usbppc_pkg::SUSP_RUN);
      s_d.irq = |(s_d.irqSt & s_d.irqMask);

      // APB answer one cycle into the access phase
      s_d.pready = psel & penable & ~s_q.pready;
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      if (psel && penable && !s_q.pready && !pwrite)
      begin
         if (hit(paddr, usbppc_pkg::OFS_POWER_SIGNAL))
            s_d.prdata = (32'(s_q.psData) << usbppc_pkg::PS_DATA_POS)
               | (32'(s_q.psValid) << usbppc_pkg::PS_VALID_POS);
         else if (hit(paddr, usbppc_pkg::OFS_PHY_CONTROL))
            s_d.prdata = (32'(s_q.pdDis) << usbppc_pkg::PC_PDDIS_POS)
               | (32'(s_q.rstCause) << usbppc_pkg::PC_RESET_POS)
               | (32'(s_q.resCause) << usbppc_pkg::PC_RESUME_POS)
               | (32'(s_q.fltLog) << usbppc_pkg::PC_FLT_POS)
               | (32'(s_q.autoRes) << usbppc_pkg::PC_AUTO_POS)
               | (32'(s_q.conf) << usbppc_pkg::PC_CONF_POS);
         else if (hit(paddr, usbppc_pkg::OFS_IRQ_STATUS))
            s_d.prdata = 32'(s_q.irqSt);
         else if (hit(paddr, usbppc_pkg::OFS_IRQ_MASK))
            s_d.prdata = 32'(s_q.irqMask);
         else if (hit(paddr, usbppc_pkg::OFS_PHY_STATUS))
            s_d.prdata = (32'(filt) << usbppc_pkg::ST_LINE_POS)
               | (32'(~s_q.suspN) << usbppc_pkg::ST_SUSP_POS);
         else
            s_d.pslverr = 1'b1;
      end
      else if (psel && penable && !s_q.pready)
      begin
         // Writes to unmapped addresses are flagged and dropped
         s_d.pslverr = ~(hit(paddr, usbppc_pkg::OFS_POWER_SIGNAL)
            | hit(paddr, usbppc_pkg::OFS_PHY_CONTROL)
            | hit(paddr, usbppc_pkg::OFS_IRQ_STATUS)
            | hit(paddr, usbppc_pkg::OFS_IRQ_MASK)
            | hit(paddr, usbppc_pkg::OFS_PHY_STATUS));
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_q <= '0;
         s_q.st <= usbppc_pkg::SUSP_RUN;
         s_q.wideEn1 <= 1'b1;
         s_q.wideEn2 <= 1'b1;
         s_q.suspN <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign transceiverConfigPins = s_q.conf;
   assign widePortFirstPdEn = s_q.wideEn1;
   assign widePortSecondPdEn = s_q.wideEn2;
   assign phySuspend_n = s_q.suspN;
   assign resumeDone = s_q.resume;
   assign powerSignalData = s_q.psData;
   assign powerSignalValid = s_q.psValid;
   assign lineStateFilt = filt;
   assign irq = s_q.irq;

   chk_power_write: assert property (@(posedge clk)
      disable iff (reset)
      (wrEn && hit(paddr, usbppc_pkg::OFS_POWER_SIGNAL))
      |=> powerSignalData == $past(pwdata[7:0])
          && powerSignalValid == $past(pwdata[8]))
      else $error("power signalling write not stored");

   chk_pulldown_ctrl: assert property (@(posedge clk)
      disable iff (reset)
      (wrEn && hit(paddr, usbppc_pkg::OFS_PHY_CONTROL))
      |=> widePortFirstPdEn == !$past(pwdata[18])
          && widePortSecondPdEn == !$past(pwdata[18]))
      else $error("pulldown enables do not follow control bit");

   chk_reset_cause: assert property (@(posedge clk)
      disable iff (reset)
      wakeSe0 |=> s_q.rstCause && s_q.st == usbppc_pkg::SUSP_WAKE
                  ##1 resumeDone == 1'b0)
      else $error("SE0 auto-resume did not set reset cause");

   chk_reset_sticky: assert property (@(posedge clk)
      disable iff (reset)
      (s_q.rstCause && !wrEn) |=> s_q.rstCause)
      else $error("reset cause cleared without a write");

   chk_resume_cause: assert property (@(posedge clk)
      disable iff (reset)
      wakeK |=> s_q.resCause && resumeDone && !phySuspend_n)
      else $error("K auto-resume did not set resume cause");

   chk_resume_sticky: assert property (@(posedge clk)
      disable iff (reset)
      (s_q.resCause && !wrEn) |=> s_q.resCause)
      else $error("resume cause cleared without a write");

   chk_manual_resume: assert property (@(posedge clk)
      disable iff (reset)
      (s_q.st == usbppc_pkg::SUSP_IDLE && !s_q.autoRes)
      |=> !resumeDone && s_q.st != usbppc_pkg::SUSP_WAKE)
      else $error("auto-resume ran while disabled");

   // Written from the line codes, not from the wake terms above
   chk_auto_wake: assert property (@(posedge clk)
      disable iff (reset)
      (s_q.st == usbppc_pkg::SUSP_IDLE && s_q.autoRes
       && (filt == usbppc_pkg::LS_SE0 || filt == usbppc_pkg::LS_K))
      |=> resumeDone)
      else $error("auto-resume did not fire on wake signalling");

   chk_config_pins: assert property (@(posedge clk)
      disable iff (reset)
      (wrEn && hit(paddr, usbppc_pkg::OFS_PHY_CONTROL))
      |=> transceiverConfigPins == $past(pwdata[6:4]))
      else $error("config pins do not follow control bits");

   chk_filter_field: assert property (@(posedge clk)
      disable iff (reset)
      (wrEn && hit(paddr, usbppc_pkg::OFS_PHY_CONTROL))
      |=> s_q.fltLog == $past(pwdata[11:8]))
      else $error("filter length field not stored");

   chk_cause_origin: assert property (@(posedge clk)
      disable iff (reset)
      ($rose(s_q.rstCause) || $rose(s_q.resCause))
      |-> $past(s_q.st) == usbppc_pkg::SUSP_IDLE
          || $past(wrEn))
      else $error("cause flag set without auto-resume");

   chk_reserved_zero: assert property (@(posedge clk)
      disable iff (reset)
      (pready && hit(paddr, usbppc_pkg::OFS_PHY_CONTROL))
      |-> prdata[31:19] == '0 && prdata[17:14] == '0
          && prdata[3:0] == '0)
      else $error("reserved control bits read as one");

   chk_ready_pulse: assert property (@(posedge clk)
      disable iff (reset)
      pready |=> !pready)
      else $error("ready stood for more than one cycle");

   chk_irq_level: assert property (@(posedge clk)
      disable iff (reset)
      $past(!wrEn) && |(s_q.irqSt & s_q.irqMask) |-> irq)
      else $error("interrupt low while unmasked status set");
endmodule : usbppc_top

/* File: tb/usbppc_phy_model.sv */
// Behavioural PHY and host line model for the power control bench
`timescale 1ns/100ps
module usbppc_phy_model (
   // Block side
   input wire logic phySuspend_n,
   // Host signalling wanted while the link is suspended
   input wire logic [1:0] wakeLine,
   // Raw line state towards the block
   output logic [1:0] lineState
);
   // Awake links idle at J; wake signalling only matters once suspended
   assign lineState = phySuspend_n ? usbppc_pkg::LS_J : wakeLine;
endmodule : usbppc_phy_model

/* File: tb/usbppc_top_tb_top.sv */
// Self-checking bench for the USB PHY power control slice
`timescale 1ns/100ps
module usbppc_top_tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, suspendReq = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdData, wd, ex;
   logic pready, pslverr, rdErr, resumeDone, powerSignalValid, irq;
   logic [1:0] lineState, lineStateFilt;
   logic [1:0] wakeLine = 2'h1;
   logic [2:0] transceiverConfigPins;
   logic widePortFirstPdEn, widePortSecondPdEn, phySuspend_n;
   logic [7:0] powerSignalData;
   int error_cnt = 0, n_compared = 0, cyc = 0, seed = 42077, t;

   usbppc_top u_usbppc_top (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .lineState(lineState), .transceiverConfigPins(transceiverConfigPins),
      .widePortFirstPdEn(widePortFirstPdEn),
      .widePortSecondPdEn(widePortSecondPdEn), .phySuspend_n(phySuspend_n),
      .suspendReq(suspendReq), .resumeDone(resumeDone),
      .powerSignalData(powerSignalData), .powerSignalValid(powerSignalValid),
      .lineStateFilt(lineStateFilt), .irq(irq));
   usbppc_phy_model u_usbppc_phy_model (.phySuspend_n(phySuspend_n),
      .wakeLine(wakeLine), .lineState(lineState));

   initial
   begin
      forever #25 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         end_sim();
      end
   end

   task end_sim;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // Signals are read before the edge updates land, so this is the sample
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      check(32'(n < 20), 32'h1);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task waitSusp;
      @(posedge clk);
      suspendReq <= 1'b1;
      t = 0;
      do
      begin
         @(posedge clk);
         t++;
      end while (phySuspend_n !== 1'b0 && t < 20);
      check(32'(phySuspend_n), 32'h0);
   endtask : waitSusp

   task done(input string name);
      $display("test %s finished", name);
   endtask : done

   initial
   begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      check(32'(transceiverConfigPins), 32'h0);
      check(32'({widePortFirstPdEn, widePortSecondPdEn}), 32'h3);
      apb(1'b0, usbppc_pkg::OFS_POWER_SIGNAL, 32'h0);
      check(rdData, 32'h0);
      apb(1'b0, usbppc_pkg::OFS_PHY_CONTROL, 32'h0);
      check(rdData, 32'h0);
      done("reset");
      for (int i = 0; i < 5; i++)
      begin
         wd = (i == 0) ? 32'hffffffff : $random(seed);
         apb(1'b1, usbppc_pkg::OFS_POWER_SIGNAL, wd);
         apb(1'b0, usbppc_pkg::OFS_POWER_SIGNAL, 32'h0);
         check(rdData, wd & 32'h000001ff);
         check(32'({powerSignalValid, powerSignalData}), 32'(wd[8:0]));
         // Cause bits left out: writing ones to them is stored
         wd = ((i == 0) ? 32'hffffffff : $random(seed)) & ~32'h00003000;
         apb(1'b1, usbppc_pkg::OFS_PHY_CONTROL, wd);
         apb(1'b0, usbppc_pkg::OFS_PHY_CONTROL, 32'h0);
         check(rdData, wd & 32'h00040ff0);
         check(32'(transceiverConfigPins), 32'(wd[6:4]));
         check(32'({widePortFirstPdEn, widePortSecondPdEn}),
            32'({2{~wd[18]}}));
      end
      apb(1'b1, 12'h100, 32'hffffffff);
      apb(1'b0, 12'h100, 32'h0);
      check({rdData[30:0], rdErr}, 32'h1);
      done("registers");
      for (int f = 0; f < 4; f += 3)
      begin
         apb(1'b1, usbppc_pkg::OFS_PHY_CONTROL, 32'(f) << 8);
         waitSusp();
         wakeLine <= usbppc_pkg::LS_K;
         t = 0;
         do
         begin
            @(posedge clk);
            t++;
         end while (lineStateFilt !== usbppc_pkg::LS_K && t < 100);
         check(32'(t), (32'h1 << f) + 32'h4);
         apb(1'b0, usbppc_pkg::OFS_PHY_STATUS, 32'h0);
         check(32'(rdData[1:0]), 32'(usbppc_pkg::LS_K));
         apb(1'b0, usbppc_pkg::OFS_PHY_CONTROL, 32'h0);
         check(32'(rdData[13:12]), 32'h0);
         wakeLine <= usbppc_pkg::LS_J;
         suspendReq <= 1'b0;
         repeat (20) @(posedge clk);
      end
      done("filter");
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, usbppc_pkg::OFS_IRQ_MASK, (k == 1) ? 32'h3 : 32'h0);
         apb(1'b1, usbppc_pkg::OFS_PHY_CONTROL, 32'h80);
         waitSusp();
         wakeLine <= (k == 1) ? usbppc_pkg::LS_SE0 : usbppc_pkg::LS_K;
         t = 0;
         do
         begin
            @(posedge clk);
            t++;
         end while (resumeDone !== 1'b1 && t < 50);
         check(32'(t < 50), 32'h1);
         wakeLine <= usbppc_pkg::LS_J;
         suspendReq <= 1'b0;
         repeat (8) @(posedge clk);
         ex = (k == 1) ? 32'h2000 : 32'h1000;
         apb(1'b0, usbppc_pkg::OFS_PHY_CONTROL, 32'h0);
         check(rdData, ex | 32'h80);
         apb(1'b0, usbppc_pkg::OFS_IRQ_STATUS, 32'h0);
         check(rdData, 32'(k + 1));
         check(32'(irq), 32'(k));
         apb(1'b1, usbppc_pkg::OFS_IRQ_MASK, 32'h3);
         repeat (2) @(posedge clk);
         check(32'(irq), 32'h1);
         apb(1'b1, usbppc_pkg::OFS_IRQ_STATUS, 32'(k + 1));
         repeat (2) @(posedge clk);
         check(32'(irq), 32'h0);
         apb(1'b1, usbppc_pkg::OFS_PHY_CONTROL, 32'h80);
         apb(1'b0, usbppc_pkg::OFS_PHY_CONTROL, 32'h0);
         check(rdData, 32'h80);
      end
      done("resume");
      // A reset in mid-run must bring every field back to its idle value
      apb(1'b1, usbppc_pkg::OFS_PHY_CONTROL, 32'h000434f0);
      apb(1'b1, usbppc_pkg::OFS_POWER_SIGNAL, 32'h000001ff);
      check(32'({widePortFirstPdEn, widePortSecondPdEn}), 32'h0);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check(32'({powerSignalValid, powerSignalData}), 32'h0);
      check(32'({widePortFirstPdEn, widePortSecondPdEn}), 32'h3);
      check(32'(transceiverConfigPins), 32'h0);
      check(32'(lineStateFilt), 32'(usbppc_pkg::LS_J));
      check(32'(irq), 32'h0);
      apb(1'b0, usbppc_pkg::OFS_PHY_CONTROL, 32'h0);
      check(rdData, 32'h0);
      done("mid-run reset");
      end_sim();
   end
endmodule : usbppc_top_tb_top
